// File: hdl/mbs_defines.vh
// Shared constants of the serial-slave frame handler.
// Assumes it is included by its bare name from each design file that uses it.
`ifndef MBS_DEFINES_VH
`define MBS_DEFINES_VH
// Function codes that the slave answers.
`define MBS_FC_READ       8'h03
`define MBS_FC_WRITE      8'h10
// Check engine preset and polynomial.
`define MBS_CRC_INIT      16'hFFFF
`define MBS_CRC_POLY      16'hA001
// Clock period and default turnaround delay, in nanoseconds.
`define MBS_CLK_NS        5
`define MBS_RESP_DELAY_NS 1000000
// Largest register quantity per frame (two bytes each, byte count fits).
`define MBS_MAX_QTY       16'h007F
// Query byte positions.
`define MBS_IDX_ADDR      9'h000
`define MBS_IDX_FUNC      9'h001
`define MBS_IDX_START_HI  9'h002
`define MBS_IDX_START_LO  9'h003
`define MBS_IDX_QTY_HI    9'h004
`define MBS_IDX_QTY_LO    9'h005
`define MBS_IDX_BCNT      9'h006
`define MBS_IDX_WR_DATA   9'h007
`define MBS_RD_QUERY_LAST 9'h007
`define MBS_WR_FIXED_LEN  9'h008
// Reply byte positions.
`define MBS_RSP_BCNT      9'h002
`define MBS_RSP_RD_DATA   9'h003
`define MBS_RSP_RD_FIXED  9'h005
`define MBS_RSP_WR_LEN    9'h008
// Value kinds offered by the register source.
`define MBS_KIND_U16      3'h0
`define MBS_KIND_U8_HI    3'h1
`define MBS_KIND_U8_LO    3'h2
`define MBS_KIND_S32_HI   3'h3
`define MBS_KIND_S32_LO   3'h4
`endif

// File: hdl/mbs_crc_byte.v
// Folds one message byte into the 16-bit frame check accumulator.
// Purely combinational; the caller holds the accumulator in a register.
`include "mbs_defines.vh"
module mbs_crc_byte (
  input  wire [15:0] i_crc,
  input  wire [7:0]  i_byte,
  output reg  [15:0] o_crc
);
  integer k; // Bit step counter.

  // Merge the byte into the high-order half, then eight shift steps.
  always @* begin
    o_crc = i_crc ^ {i_byte, 8'h00};
    for (k = 0; k < 8; k = k + 1) begin
      if (o_crc[0]) begin
        o_crc = (o_crc >> 1) ^ `MBS_CRC_POLY;
      end else begin
        o_crc = o_crc >> 1;
      end
    end
  end
endmodule

// File: hdl/mbs_skid2.v
// Two-entry buffer with valid and ready on both sides.
// Assumes the drain side may hold ready low for any time.
module mbs_skid2 #(
  parameter W = 9
) (
  input  wire         i_clk_sys,
  input  wire         i_sys_rst,
  input  wire         i_in_valid,
  input  wire [W-1:0] i_in_data,
  output wire         o_in_ready,
  output reg          o_out_valid,
  output reg  [W-1:0] o_out_data,
  input  wire         i_out_ready
);
  reg         skid_v_reg; // Second entry holds a word.
  reg [W-1:0] skid_reg;   // Second entry storage.

  // Accept only while the second entry is free, so nothing is lost.
  assign o_in_ready = ~skid_v_reg;

  // Output entry refills from the second entry first, keeping order.
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_out_valid <= 1'b0;
      o_out_data  <= {W{1'b0}};
      skid_v_reg  <= 1'b0;
      skid_reg    <= {W{1'b0}};
    end else if (!o_out_valid || i_out_ready) begin
      if (skid_v_reg) begin
        o_out_data  <= skid_reg;
        o_out_valid <= 1'b1;
        skid_v_reg  <= 1'b0;
      end else begin
        o_out_data  <= i_in_data;
        o_out_valid <= i_in_valid;
      end
    end else if (i_in_valid && !skid_v_reg) begin
      // Receiver stalls: park the word in the second entry.
      skid_reg   <= i_in_data;
      skid_v_reg <= 1'b1;
    end
  end
endmodule

// File: hdl/mbs_slave.v
// Serial-slave frame handler: parses read and write queries,
// drives the register port and streams the reply bytes out.
// Assumes framing is done outside: i_rx_last marks each frame's last byte.
// Register values are sampled in the same cycle that o_reg_rd_en is high.
`include "mbs_defines.vh"
// How it works
// - Read query and reply carry the listed fields.
// - Write reply echoes start and quantity, no data.
// - Start register sent high byte then low.
// - Register quantity sent high byte then low.
// - Byte count is one byte, 0 to 255.
// - Data bytes equal twice the register quantity.
// - Frame ends with check, high byte first.
// - Check accumulator presets to all ones.
// - Each byte merges into the high-order half.
// - Each step shifts right, zero fill, keeps bit.
// - Shifted-out one applies the polynomial.
// - Exactly eight steps per byte.
// - Repeat per byte; final value is check.
// - Byte values sit in upper or lower half.
// - Unsigned 16-bit values fill one register.
// - Signed 32-bit values span two registers.
// - Signed 32-bit values use sign-magnitude coding.
// - Only read and write-multiple functions answered.
// - Multidrop lines wait a configurable reply delay.
module mbs_slave #(
  parameter [15:0] MAX_QTY       = `MBS_MAX_QTY,
  parameter        RESP_DELAY_NS = `MBS_RESP_DELAY_NS
) (
  input  wire        i_clk_sys,
  input  wire        i_sys_rst,
  input  wire        i_rx_valid,
  input  wire [7:0]  i_rx_data,
  input  wire        i_rx_last,
  input  wire [7:0]  i_dev_addr,
  input  wire        i_multidrop,
  output reg         o_busy,
  output reg         o_frame_ok,
  output reg         o_frame_drop,
  output reg         o_reg_rd_en,
  output reg         o_reg_wr_en,
  output reg  [15:0] o_reg_addr,
  output reg  [15:0] o_reg_wr_data,
  input  wire [2:0]  i_reg_rd_kind,
  input  wire [31:0] i_reg_rd_val,
  output wire        o_tx_valid,
  output wire [7:0]  o_tx_data,
  output wire        o_tx_last,
  input  wire        i_tx_ready
);
  // Turnaround delay as whole cycles, rounded up, never below one.
  localparam integer DLY_RAW = (RESP_DELAY_NS + `MBS_CLK_NS - 1) / `MBS_CLK_NS;
  localparam integer DLY_CYC = (DLY_RAW < 1) ? 1 : DLY_RAW;

  // Handler states.
  localparam [1:0] S_RX  = 2'h0;
  localparam [1:0] S_WR  = 2'h1;
  localparam [1:0] S_DLY = 2'h2;
  localparam [1:0] S_TX  = 2'h3;

  reg  [1:0]  state_reg;      // Current handler state.
  reg  [8:0]  rx_idx_reg;     // Position of the next query byte.
  reg         rx_bad_reg;     // Query overran the byte counter.
  reg  [7:0]  addr_reg;       // Received device address.
  reg  [7:0]  fc_reg;         // Received function code.
  reg  [7:0]  bc_reg;         // Received byte count field.
  reg  [7:0]  hold_reg;       // Previous query byte.
  reg  [15:0] start_reg;      // Starting register.
  reg  [15:0] qty_reg;        // Register quantity.
  reg  [15:0] rx_crc_reg;     // Check over all bytes so far.
  reg  [15:0] rx_crc_p1_reg;  // Check before the latest byte.
  reg  [15:0] wbuf [0:MAX_QTY-1]; // Write data held until the check passes.
  reg  [15:0] k_reg;          // Register counter for writes and reads.
  reg  [31:0] dly_reg;        // Turnaround counter.
  reg  [8:0]  tx_idx_reg;     // Position of the next reply byte.
  reg  [15:0] tx_crc_reg;     // Check over reply bytes so far.
  reg  [15:0] word_reg;       // Formatted register word being sent.
  reg         word_have_reg;  // Word register holds fresh data.
  reg         rd_pend_reg;    // A register read is in flight.

  wire [15:0] rx_crc_next;    // Check after folding the incoming byte.
  wire [15:0] tx_crc_next;    // Check after folding the outgoing byte.
  wire        fifo_in_ready;  // Output buffer can take a byte.
  wire [8:0]  fifo_out;       // Buffered last flag and byte.
  wire [8:0]  rx_dat_off;     // Offset inside the write data.
  wire        is_read;        // Query is a read.
  wire        is_write;       // Query is a write.
  wire [7:0]  rsp_bc;         // Reply byte count for reads.
  wire [8:0]  rd_data_end;    // First reply index past the data.
  wire [8:0]  tx_total;       // Reply length in bytes.
  wire        tx_is_data;     // Reply index is a data byte.
  wire        tx_is_crc;      // Reply index is a check byte.
  wire        tx_avail;       // Reply byte ready to push.
  wire        tx_last;        // Reply index is the final byte.
  wire        qty_ok;         // Quantity within 1..MAX_QTY.
  wire        crc_ok;         // Received check matches.
  wire        frame_good;     // Whole query is acceptable.
  reg  [7:0]  tx_byte;        // Reply byte at the current index.
  reg  [15:0] fmt_word;       // Register value in wire format.
  reg  [31:0] mag;            // Magnitude of a signed value.

  mbs_crc_byte u_rx_crc (
    .i_crc  (rx_crc_reg),
    .i_byte (i_rx_data),
    .o_crc  (rx_crc_next)
  );

  mbs_crc_byte u_tx_crc (
    .i_crc  (tx_crc_reg),
    .i_byte (tx_byte),
    .o_crc  (tx_crc_next)
  );

  mbs_skid2 #(.W(9)) u_buf (
    .i_clk_sys   (i_clk_sys),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (state_reg == S_TX && tx_avail),
    .i_in_data   ({tx_last, tx_byte}),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (o_tx_valid),
    .o_out_data  (fifo_out),
    .i_out_ready (i_tx_ready)
  );
  assign o_tx_data = fifo_out[7:0];
  assign o_tx_last = fifo_out[8];

  // Query decoding terms.
  assign is_read     = (fc_reg == `MBS_FC_READ);
  assign is_write    = (fc_reg == `MBS_FC_WRITE);
  assign rx_dat_off  = rx_idx_reg - `MBS_IDX_WR_DATA;
  assign qty_ok      = (qty_reg != 16'h0000) && (qty_reg <= MAX_QTY);
  // Received check is the byte before the last, then the last.
  assign crc_ok      = (rx_crc_p1_reg == {hold_reg, i_rx_data});
  // Only the two functions, exact length, matching count and address.
  assign frame_good  = !rx_bad_reg && crc_ok && (addr_reg == i_dev_addr) && qty_ok &&
                       ((is_read && rx_idx_reg == `MBS_RD_QUERY_LAST) ||
                        (is_write && {1'b0, bc_reg} == {qty_reg[7:0], 1'b0} &&
                         rx_idx_reg == `MBS_WR_FIXED_LEN + {1'b0, bc_reg}));

  // Reply layout terms.
  assign rsp_bc      = {qty_reg[6:0], 1'b0};
  assign rd_data_end = `MBS_RSP_RD_DATA + {1'b0, rsp_bc};
  assign tx_total    = is_read ? (`MBS_RSP_RD_FIXED + {1'b0, rsp_bc}) : `MBS_RSP_WR_LEN;
  assign tx_is_data  = is_read && tx_idx_reg >= `MBS_RSP_RD_DATA && tx_idx_reg < rd_data_end;
  assign tx_is_crc   = tx_idx_reg >= tx_total - 9'h002;
  assign tx_avail    = !tx_is_data || word_have_reg;
  assign tx_last     = (tx_idx_reg == tx_total - 9'h001);

  // Reply byte selection by index.
  always @* begin
    tx_byte = 8'h00;
    if (tx_is_crc) begin
      tx_byte = tx_last ? tx_crc_reg[7:0] : tx_crc_reg[15:8];
    end else if (tx_is_data) begin
      // Even offsets send the upper half first.
      tx_byte = tx_idx_reg[0] ? word_reg[15:8] : word_reg[7:0];
    end else begin
      case (tx_idx_reg)
        `MBS_IDX_ADDR:     tx_byte = addr_reg;
        `MBS_IDX_FUNC:     tx_byte = fc_reg;
        `MBS_IDX_START_HI: tx_byte = is_read ? rsp_bc : start_reg[15:8];
        `MBS_IDX_START_LO: tx_byte = start_reg[7:0];
        `MBS_IDX_QTY_HI:   tx_byte = qty_reg[15:8];
        `MBS_IDX_QTY_LO:   tx_byte = qty_reg[7:0];
        default:           tx_byte = 8'h00;
      endcase
    end
  end

  // Register value to wire format, by kind.
  always @* begin
    mag = i_reg_rd_val[31] ? (~i_reg_rd_val + 32'h0000_0001) : i_reg_rd_val;
    // The most negative value has no magnitude in 31 bits; it saturates.
    if (mag[31]) begin
      mag = 32'h7FFF_FFFF;
    end
    mag = {i_reg_rd_val[31], mag[30:0]};
    case (i_reg_rd_kind)
      `MBS_KIND_U8_HI:  fmt_word = {i_reg_rd_val[7:0], 8'h00};
      `MBS_KIND_U8_LO:  fmt_word = {8'h00, i_reg_rd_val[7:0]};
      `MBS_KIND_S32_HI: fmt_word = mag[31:16];
      `MBS_KIND_S32_LO: fmt_word = mag[15:0];
      default:          fmt_word = i_reg_rd_val[15:0];
    endcase
  end

  // Write data capture; pairs of bytes form one register, high first.
  always @(posedge i_clk_sys) begin
    if (state_reg == S_RX && i_rx_valid && is_write && rx_idx_reg >= `MBS_IDX_WR_DATA &&
        rx_dat_off[0] && {8'h00, rx_dat_off[8:1]} < MAX_QTY) begin
      wbuf[rx_dat_off[7:1]] <= {hold_reg, i_rx_data};
    end
  end

  // Main sequencer: receive, apply writes, wait, send reply.
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg     <= S_RX;
      rx_idx_reg    <= 9'h000;
      rx_bad_reg    <= 1'b0;
      addr_reg      <= 8'h00;
      fc_reg        <= 8'h00;
      bc_reg        <= 8'h00;
      hold_reg      <= 8'h00;
      start_reg     <= 16'h0000;
      qty_reg       <= 16'h0000;
      rx_crc_reg    <= `MBS_CRC_INIT;
      rx_crc_p1_reg <= `MBS_CRC_INIT;
      k_reg         <= 16'h0000;
      dly_reg       <= 32'h0000_0000;
      tx_idx_reg    <= 9'h000;
      tx_crc_reg    <= `MBS_CRC_INIT;
      word_reg      <= 16'h0000;
      word_have_reg <= 1'b0;
      rd_pend_reg   <= 1'b0;
      o_busy        <= 1'b0;
      o_frame_ok    <= 1'b0;
      o_frame_drop  <= 1'b0;
      o_reg_rd_en   <= 1'b0;
      o_reg_wr_en   <= 1'b0;
      o_reg_addr    <= 16'h0000;
      o_reg_wr_data <= 16'h0000;
    end else begin
      // Strobes last one cycle unless set again below.
      o_frame_ok   <= 1'b0;
      o_frame_drop <= 1'b0;
      o_reg_rd_en  <= 1'b0;
      o_reg_wr_en  <= 1'b0;
      case (state_reg)
        S_RX: begin
          o_busy <= 1'b0;
          if (i_rx_valid) begin
            hold_reg      <= i_rx_data;
            rx_crc_p1_reg <= rx_crc_reg;
            rx_crc_reg    <= rx_crc_next;
            // Capture header fields by position.
            case (rx_idx_reg)
              `MBS_IDX_ADDR:    addr_reg <= i_rx_data;
              `MBS_IDX_FUNC:    fc_reg <= i_rx_data;
              `MBS_IDX_START_LO: start_reg <= {hold_reg, i_rx_data};
              `MBS_IDX_QTY_LO:  qty_reg <= {hold_reg, i_rx_data};
              `MBS_IDX_BCNT:    bc_reg <= i_rx_data;
              default:          bc_reg <= bc_reg;
            endcase
            // Saturate the position; an overlong frame is refused.
            if (rx_idx_reg == 9'h1FF) begin
              rx_bad_reg <= 1'b1;
            end else begin
              rx_idx_reg <= rx_idx_reg + 9'h001;
            end
            if (i_rx_last) begin
              // Next frame starts from a fresh preset.
              rx_idx_reg    <= 9'h000;
              rx_bad_reg    <= 1'b0;
              rx_crc_reg    <= `MBS_CRC_INIT;
              rx_crc_p1_reg <= `MBS_CRC_INIT;
              k_reg         <= 16'h0000;
              dly_reg       <= 32'h0000_0000;
              if (frame_good) begin
                o_frame_ok <= 1'b1;
                o_busy     <= 1'b1;
                state_reg  <= is_write ? S_WR : S_DLY;
              end else begin
                o_frame_drop <= 1'b1;
              end
            end
          end
        end
        S_WR: begin
          // Apply the held writes in ascending order.
          if (k_reg == qty_reg) begin
            state_reg <= S_DLY;
          end else begin
            o_reg_wr_en   <= 1'b1;
            o_reg_addr    <= start_reg + k_reg;
            o_reg_wr_data <= wbuf[k_reg[6:0]];
            k_reg         <= k_reg + 16'h0001;
          end
        end
        S_DLY: begin
          // Multidrop lines hold off the reply; point-to-point do not.
          if (!i_multidrop || dly_reg == DLY_CYC - 1) begin
            state_reg     <= S_TX;
            tx_idx_reg    <= 9'h000;
            tx_crc_reg    <= `MBS_CRC_INIT;
            k_reg         <= 16'h0000;
            word_have_reg <= 1'b0;
            rd_pend_reg   <= 1'b0;
          end else begin
            dly_reg <= dly_reg + 32'h0000_0001;
          end
        end
        S_TX: begin
          // Fetch the next register once the index reaches its first byte.
          if (tx_is_data && !word_have_reg && !rd_pend_reg) begin
            o_reg_rd_en <= 1'b1;
            o_reg_addr  <= start_reg + k_reg;
            rd_pend_reg <= 1'b1;
          end
          if (rd_pend_reg) begin
            word_reg      <= fmt_word;
            word_have_reg <= 1'b1;
            rd_pend_reg   <= 1'b0;
          end
          // Push one byte whenever the buffer takes it.
          if (tx_avail && fifo_in_ready) begin
            tx_idx_reg <= tx_idx_reg + 9'h001;
            if (!tx_is_crc) begin
              tx_crc_reg <= tx_crc_next;
            end
            if (tx_is_data && !tx_idx_reg[0]) begin
              word_have_reg <= 1'b0;
              k_reg         <= k_reg + 16'h0001;
            end
            if (tx_last) begin
              state_reg <= S_RX;
            end
          end
        end
        default: begin
          state_reg <= S_RX;
        end
      endcase
    end
  end
endmodule

// File: testbench/mbs_slave_monitor.sv
// Port checker for the frame handler: acceptance, silence, reply buffering, register strobes.
// Assumes binding to mbs_slave and a reply delay of at least eight cycles on multidrop lines.
module mbs_slave_monitor #(
  parameter [15:0] MAX_QTY       = 16'h007F,
  parameter        RESP_DELAY_NS = 50
) (
  input wire        i_clk_sys,
  input wire        i_sys_rst,
  input wire        i_rx_valid,
  input wire [7:0]  i_rx_data,
  input wire        i_rx_last,
  input wire [7:0]  i_dev_addr,
  input wire        i_multidrop,
  input wire        o_busy,
  input wire        o_frame_ok,
  input wire        o_frame_drop,
  input wire        o_reg_rd_en,
  input wire        o_reg_wr_en,
  input wire [15:0] o_reg_addr,
  input wire [15:0] o_reg_wr_data,
  input wire [2:0]  i_reg_rd_kind,
  input wire [31:0] i_reg_rd_val,
  input wire        o_tx_valid,
  input wire [7:0]  o_tx_data,
  input wire        o_tx_last,
  input wire        i_tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  reg first_reg;  // High while the next reply byte opens a reply.
  // Re-arms after each last byte so every reply start is seen.
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      first_reg <= 1'b1;
    end else if (o_tx_valid && i_tx_ready) begin
      first_reg <= o_tx_last;
    end
  end
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_sys_rst);
  // Last query byte taken while idle.
  sequence s_last_taken;
    i_rx_valid && i_rx_last && !o_busy;
  endsequence
  // Frame accepted on a multidrop line with the reply path empty.
  sequence s_md_accept;
    o_frame_ok && i_multidrop && !o_tx_valid;
  endsequence
  frame_answer_a: assert property (s_last_taken |=> o_frame_ok != o_frame_drop)
    else $error("frame end gave no single verdict");
  drop_quiet_a: assert property (o_frame_drop |-> !o_busy && !o_frame_ok ##1 !o_busy)
    else $error("dropped frame started a reply");
  busy_rise_a: assert property ($rose(o_busy) |-> o_frame_ok)
    else $error("busy rose without an accepted frame");
  busy_end_a: assert property ($fell(o_busy) |-> $past(o_tx_valid))
    else $error("reply finished without a byte waiting");
  tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data) && $stable(o_tx_last))
    else $error("reply byte changed while stalled");
  reply_addr_a: assert property (o_tx_valid && first_reg |-> o_tx_data == i_dev_addr)
    else $error("reply does not open with the device address");
  wr_inside_a: assert property (o_reg_wr_en |-> o_busy && !o_frame_ok)
    else $error("register write outside an accepted frame");
  wr_ascend_a: assert property (o_reg_wr_en && $past(o_reg_wr_en) |-> o_reg_addr == $past(o_reg_addr) + 16'h0001)
    else $error("register writes not ascending");
  rd_single_a: assert property (o_reg_rd_en |=> !o_reg_rd_en)
    else $error("two register reads outstanding");
  delay_quiet_a: assert property (s_md_accept |-> !o_tx_valid [*8])
    else $error("multidrop reply came too early");
endmodule
bind mbs_slave mbs_slave_monitor #(.MAX_QTY(MAX_QTY), .RESP_DELAY_NS(RESP_DELAY_NS)) mon_u (
  .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data),
  .i_rx_last(i_rx_last), .i_dev_addr(i_dev_addr), .i_multidrop(i_multidrop), .o_busy(o_busy),
  .o_frame_ok(o_frame_ok), .o_frame_drop(o_frame_drop), .o_reg_rd_en(o_reg_rd_en),
  .o_reg_wr_en(o_reg_wr_en), .o_reg_addr(o_reg_addr), .o_reg_wr_data(o_reg_wr_data),
  .i_reg_rd_kind(i_reg_rd_kind), .i_reg_rd_val(i_reg_rd_val), .o_tx_valid(o_tx_valid),
  .o_tx_data(o_tx_data), .o_tx_last(o_tx_last), .i_tx_ready(i_tx_ready));

// File: testbench/mbs_regsrc_model.sv
// Register source behind the frame handler: sixteen words, kinds fixed by address.
// Assumes the handler takes kind and value at the edge that ends its read strobe.
module mbs_regsrc_model (
  input  wire        i_clk_sys,
  input  wire        i_sys_rst,
  input  wire        i_rd_en,
  input  wire        i_wr_en,
  input  wire [15:0] i_addr,
  input  wire [15:0] i_wr_data,
  output reg  [2:0]  o_kind,
  output reg  [31:0] o_val
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [31:0] mem [0:15];  // Stored values, two's complement for signed kinds.
  integer    k;           // Reset loop index.
  // Stores writes raw; signed kinds are preset in two's complement.
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (k = 0; k < 16; k = k + 1) begin
        mem[k] <= 32'h00005A00 + k;
      end
      mem[0] <= 32'h00001234;  // Unsigned 16-bit word.
      mem[1] <= 32'h000000AB;  // Byte for the upper half.
      mem[2] <= 32'h000000CD;  // Byte for the lower half.
      mem[3] <= 32'hFFFFFFFB;  // Minus five, upper register.
      mem[4] <= 32'h00012345;  // Positive value, lower register.
    end else begin
      if (i_wr_en) begin
        mem[i_addr[3:0]] <= {16'h0000, i_wr_data};
      end
    end
  end
  // Shows the addressed word only while the read strobe stands, so a late sample reads zero.
  always_comb begin
    o_kind = 3'h0;
    o_val  = 32'h00000000;
    if (i_rd_en) begin
      o_kind = (i_addr < 16'h0005) ? i_addr[2:0] : 3'h0;
      o_val  = mem[i_addr[3:0]];
    end
  end
endmodule

// File: testbench/tb.sv
// Self-checking bench for the frame handler with its register source model.
// Assumes a 200 MHz clock and a reply delay shortened to 50 ns (10 cycles).
`define CHK(nm, exp, got) begin n_compared++; if ((exp) !== (got)) begin failures++; \
  $display("BAD %s exp %0h got %0h", nm, exp, got); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [7:0] DEV = 8'h11;  // Configured slave address.
  logic       clk, rst, rx_valid, rx_last, multidrop, stall;
  logic       ready = 1'b1;
  logic [7:0] rx_data;
  wire        busy, ok_p, drop_p, rd_en, wr_en, tx_valid, tx_last;
  wire [15:0] reg_addr, wr_data;
  wire [2:0]  kind;
  wire [31:0] val;
  wire [7:0]  tx_data;
  int         failures = 0, n_compared = 0, cyc = 0, first_cyc = 0;
  logic [7:0] fr[$], ex[$];
  mbs_slave #(.RESP_DELAY_NS(50)) dut_u (.i_clk_sys(clk), .i_sys_rst(rst), .i_rx_valid(rx_valid),
    .i_rx_data(rx_data), .i_rx_last(rx_last), .i_dev_addr(DEV), .i_multidrop(multidrop), .o_busy(busy),
    .o_frame_ok(ok_p), .o_frame_drop(drop_p), .o_reg_rd_en(rd_en), .o_reg_wr_en(wr_en),
    .o_reg_addr(reg_addr), .o_reg_wr_data(wr_data), .i_reg_rd_kind(kind), .i_reg_rd_val(val),
    .o_tx_valid(tx_valid), .o_tx_data(tx_data), .o_tx_last(tx_last), .i_tx_ready(ready));
  mbs_regsrc_model reg_u (.i_clk_sys(clk), .i_sys_rst(rst), .i_rd_en(rd_en), .i_wr_en(wr_en),
    .i_addr(reg_addr), .i_wr_data(wr_data), .o_kind(kind), .o_val(val));
  // Free-running 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Cycle count, receiver stalls (15 of 16 cycles when asked) and hang guard.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ready <= !stall || (cyc[3:0] == 4'hF);
    if (cyc == 20000) begin
      failures++;
      test_done;
    end
  end
  // Check value: preset, merge into the upper byte, eight right shifts.
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {q[i], 8'h00};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction
  // Sends the frame in fr with its check (optionally spoiled) and returns the verdict pulses.
  task send(input logic bad, output logic ok, output logic drop);
    logic [15:0] c;
    c = crc16(fr) ^ {15'h0000, bad};
    fr.push_back(c[15:8]);
    fr.push_back(c[7:0]);
    foreach (fr[i]) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= fr[i];
      rx_last <= (i == fr.size() - 1);
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    @(posedge clk);
    ok = ok_p;
    drop = drop_p;
  endtask
  // Collects the reply byte by byte and compares it with ex plus its check.
  task expect_reply;
    logic [15:0] c;
    int          i, w;
    c = crc16(ex);
    ex.push_back(c[15:8]);
    ex.push_back(c[7:0]);
    i = 0;
    w = 0;
    while (i < ex.size() && w < 4000) begin
      @(posedge clk);
      w++;
      if (tx_valid === 1'b1 && ready === 1'b1) begin
        if (i == 0) first_cyc = cyc;
        `CHK("reply byte", ex[i], tx_data)
        `CHK("reply last", (i == ex.size() - 1), tx_last)
        i++;
      end
    end
    `CHK("reply length", ex.size(), i)
  endtask
  // Read of every value kind in one frame.
  task t_read_kinds;
    logic ok, drop;
    fr = '{DEV, 8'h03, 8'h00, 8'h00, 8'h00, 8'h05};
    send(1'b0, ok, drop);
    `CHK("read accepted", 1'b1, ok)
    ex = '{DEV, 8'h03, 8'h0A, 8'h12, 8'h34, 8'hAB, 8'h00, 8'h00, 8'hCD, 8'h80, 8'h00, 8'h23, 8'h45};
    expect_reply;
  endtask
  // Write of two registers, then read back through a stalling receiver.
  task t_write_back;
    logic ok, drop;
    fr = '{DEV, 8'h10, 8'h00, 8'h08, 8'h00, 8'h02, 8'h04, 8'hBE, 8'hEF, 8'h00, 8'h11};
    send(1'b0, ok, drop);
    `CHK("write accepted", 1'b1, ok)
    ex = '{DEV, 8'h10, 8'h00, 8'h08, 8'h00, 8'h02};
    expect_reply;
    `CHK("reg 8", 32'h0000BEEF, reg_u.mem[8])
    `CHK("reg 9", 32'h00000011, reg_u.mem[9])
    stall = 1'b1;
    fr = '{DEV, 8'h03, 8'h00, 8'h08, 8'h00, 8'h02};
    send(1'b0, ok, drop);
    ex = '{DEV, 8'h03, 8'h04, 8'hBE, 8'hEF, 8'h00, 8'h11};
    expect_reply;
    stall = 1'b0;
  endtask
  // Foreign address, unknown function, bad check and wrong byte count all stay silent.
  task t_drops;
    logic ok, drop, seen;
    for (int k = 0; k < 4; k++) begin
      case (k)
        0: fr = '{8'h12, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
        1: fr = '{DEV, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01};
        2: fr = '{DEV, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
        default: fr = '{DEV, 8'h10, 8'h00, 8'h08, 8'h00, 8'h02, 8'h03, 8'hAA, 8'hBB, 8'hCC};
      endcase
      send(k == 2, ok, drop);
      `CHK("frame dropped", 1'b1, drop)
      `CHK("frame not accepted", 1'b0, ok)
      seen = 1'b0;
      repeat (20) @(posedge clk) seen = seen | tx_valid;
      `CHK("no reply", 1'b0, seen)
    end
    `CHK("reg 8 kept", 32'h0000BEEF, reg_u.mem[8])
  endtask
  // Multidrop line: reply held back by the configured delay.
  task t_delay;
    logic ok, drop;
    int   t0;
    @(posedge clk);
    multidrop <= 1'b1;
    fr = '{DEV, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
    send(1'b0, ok, drop);
    t0 = cyc;
    ex = '{DEV, 8'h03, 8'h02, 8'h12, 8'h34};
    expect_reply;
    `CHK("reply delay", 1'b1, (first_cyc - t0 >= 10))
    multidrop <= 1'b0;
  endtask
  // Prints the verdict and ends the run.
  task test_done;
    if (failures == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Reset for ten cycles, then the scenarios in turn.
  initial begin
    rst = 1'b1;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    multidrop = 1'b0;
    stall = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_read_kinds;
    t_write_back;
    t_drops;
    t_delay;
    test_done;
  end
endmodule
